/* tb_top.sv */
// self-checking bench for the token and frame register block
`timescale 1ns/10ps
module tb_top;
  import utfr_pkg::*;
  localparam int FC = 50;
  logic        clk = 1'b0, rst = 1'b1, hostMode = 1'b0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, thresholdCount;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, x, m [6] = '{default: '0};
  logic [3:0]  s_axi_wstrb = 4'hf, tokenEndpoint;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic        s_axi_bready = 0, s_axi_rready = 0, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        rxFrameStart, tokenDone, tokenStart, tokenLowSpeed;
  logic        tokenInProgress, frameStartSend;
  logic [10:0] rxFrameNumber;
  logic [6:0]  targetAddress = '0, tokenAddress;
  logic [4:0]  doneDelay = 5'd1;
  logic [31:0] seed = 32'h6f86;
  logic [7:0]  tv [4] = '{8'h4a, 8'h2a, 8'h1a, 8'h12};
  logic [3:0]  pids [3] = '{4'h1, 4'h9, 4'hd};
  utfr_token_kind_type kinds [3] = '{UTFR_TOK_OUT, UTFR_TOK_IN, UTFR_TOK_SETUP};
  utfr_token_kind_type tokenKind;
  int          n_mismatch = 0, total_checks = 0, i, k;
  utfr_regs #(.FRAME_CYCLES(FC)) u_utfr_regs (.*);
  utfr_link_model u_utfr_link_model (.*);
  initial forever #2.5 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic print_verdict();
    if (n_mismatch == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tmo();
    n_mismatch++;
    print_verdict();
  endtask : tmo
  // ready is looked at mid-cycle, released just after the taking edge
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    for (int j = 0; j < 64 && !b; j++) begin
      @(negedge clk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid & s_axi_bready;
      if (b) chk({30'h0, s_axi_bresp}, 32'h0);
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      s_axi_bready <= !b && j >= 2;
    end
    if (!b) tmo();
  endtask : axiWr
  // read compared with the bench's register model
  task automatic rc(input logic [7:0] a);
    logic ar, v;
    v = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int j = 0; j < 64 && !v; j++) begin
      @(negedge clk);
      ar = s_axi_arready;
      v = s_axi_rvalid & s_axi_rready;
      if (v) chk(s_axi_rdata, a < 8'h18 ? m[a[4:2]] : 32'h0);
      if (v) chk({30'h0, s_axi_rresp}, a < 8'h18 ? 32'h0 : 32'h2);
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
      s_axi_rready <= !v && j >= 2;
    end
    if (!v) tmo();
  endtask : rc
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 7; i++) rc(8'(i * 4));
    for (i = 0; i < 8; i++) begin
      x = rnd();
      if (i < 4) x[7:0] = tv[i];
      axiWr(8'h0c, x);
      m[3] = {24'h0, x[7:0]};
      rc(8'h0c);
      chk(thresholdCount, x[7:0]);
    end
    for (i = 0; i < 3; i++) begin
      x = (i == 2) ? 32'hffff_ffff : rnd();
      u_utfr_link_model.sendFrame(x[10:0]);
      m[0] = {24'h0, x[7:0]};
      m[1] = {29'h0, x[10:8]};
      axiWr(8'h00, 32'hffff_ffff);
      axiWr(8'h18, 32'hffff_ffff);
      rc(8'h00);
      rc(8'h04);
    end
    for (i = 0; i < 6; i++) begin
      x = rnd();
      targetAddress <= x[14:8];
      doneDelay <= (i % 2) ? 5'd20 : 5'd1;
      m[4] = {24'h0, x[16], 7'h0};
      axiWr(8'h10, m[4]);
      m[2] = {24'h0, pids[i % 3], x[3:0]};
      axiWr(8'h08, m[2]);
      chk(tokenKind, kinds[i % 3]);
      chk(tokenEndpoint, x[3:0]);
      chk(tokenAddress, x[14:8]);
      chk(tokenLowSpeed, x[16]);
      rc(8'h08);
      m[5] = {30'h0, x[16], 1'b1};
      if (i % 2) rc(8'h14);
      for (k = 0; k < 200 && tokenInProgress !== 1'b0; k++) @(posedge clk);
      if (k == 200) tmo();
      repeat (8) @(posedge clk);
      m[5] = {30'h0, x[16], 1'b0};
      rc(8'h14);
    end
    hostMode <= 1'b1;
    axiWr(8'h10, 32'h100);
    for (k = 0; k < 4 * FC && frameStartSend !== 1'b1; k++) @(posedge clk);
    if (k == 4 * FC) tmo();
    @(posedge clk);
    for (k = 1; k < 4 * FC && frameStartSend !== 1'b1; k++) @(posedge clk);
    chk(k, FC);
    hostMode <= 1'b0;
    repeat (4) @(posedge clk);
    i = 0;
    repeat (2 * FC) begin
      @(posedge clk);
      if (frameStartSend !== 1'b0) i++;
    end
    chk(i, 0);
    print_verdict();
  end
endmodule : tb_top
bind utfr_regs utfr_regs_props #(.FRAME_CYCLES(FRAME_CYCLES)) u_utfr_regs_props (.*);

/* utfr_consts.svh */
// register offsets, field positions, reset values and timing counts
`ifndef UTFR_CONSTS_SVH
`define UTFR_CONSTS_SVH
`define UTFR_OFF_FRAME_LOW   8'h00
`define UTFR_OFF_FRAME_HIGH  8'h04
`define UTFR_OFF_TOKEN       8'h08
`define UTFR_OFF_THRESHOLD   8'h0c
`define UTFR_OFF_CONTROL     8'h10
`define UTFR_OFF_STATUS      8'h14
`define UTFR_CTL_LOWSPEED    7
`define UTFR_CTL_FRAME_START_GENERATION_ENABLE       8
`define UTFR_STS_BUSY        0
`define UTFR_STS_LOWSPEED    1
`define UTFR_RESET_BYTE      8'h00
`define UTFR_PID_OUT         4'h1
`define UTFR_PID_IN          4'h9
`define UTFR_PID_SETUP       4'hd
`define UTFR_CLK_MHZ         200
`define UTFR_FRAME_US        1000
`define UTFR_FRAME_CYCLES    (`UTFR_FRAME_US * `UTFR_CLK_MHZ)
`endif

/* utfr_frame_tick.sv */
// one-millisecond frame-start tick divider
`timescale 1ns/10ps
`include "utfr_consts.svh"
module utfr_frame_tick #(
  parameter int FRAME_CYCLES = `UTFR_FRAME_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic enable,
  output logic      tick
);
  typedef struct packed {
    logic [31:0] count;
    logic        tick;
  } utfr_tick_state_type;
  utfr_tick_state_type state_q;
  utfr_tick_state_type state_d;

  always_comb begin
    state_d      = state_q;
    state_d.tick = 1'b0;
    if (!enable) begin
      state_d.count = '0;
    end else if (state_q.count == 32'(FRAME_CYCLES - 1)) begin
      state_d.count = '0;
      state_d.tick  = 1'b1;
    end else begin
      state_d.count = state_q.count + 32'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign tick = state_q.tick;
endmodule : utfr_frame_tick

/* utfr_link_model.sv */
// link partner: sends frame-start tokens, completes issued tokens
`timescale 1ns/10ps
module utfr_link_model (
  input  wire logic        clk,
  input  wire logic        tokenInProgress,
  input  wire logic [4:0]  doneDelay,
  output logic             rxFrameStart,
  output logic [10:0]      rxFrameNumber,
  output logic             tokenDone
);
  initial begin
    rxFrameStart = 1'b0;
    rxFrameNumber = 11'h2a5;
    tokenDone = 1'b0;
  end
  // pause set by the bench: prompt or slow answer
  always begin
    @(posedge clk);
    if (tokenInProgress === 1'b1) begin
      repeat (doneDelay) @(posedge clk);
      tokenDone <= 1'b1;
      repeat (6) @(posedge clk);
      tokenDone <= 1'b0;
    end
  end
  // number held well around the synchronised edge
  task automatic sendFrame(input logic [10:0] n);
    rxFrameNumber <= n;
    repeat (3) @(posedge clk);
    rxFrameStart <= 1'b1;
    repeat (6) @(posedge clk);
    rxFrameStart <= 1'b0;
    repeat (3) @(posedge clk);
    rxFrameNumber <= ~n;
  endtask : sendFrame
endmodule : utfr_link_model

/* utfr_pkg.sv */
// types shared by the token and frame register block
package utfr_pkg;
  typedef enum logic [1:0] {
    UTFR_TOK_NONE,
    UTFR_TOK_OUT,
    UTFR_TOK_IN,
    UTFR_TOK_SETUP
  } utfr_token_kind_type;
endpackage : utfr_pkg

/* utfr_regs.sv */
// token command, frame number and frame-start threshold registers
//
// Summary of operation
// - low frame byte readable, upper bits zero
// - top three frame bits in bits 2..0
// - received frame-start token loads frame number
// - unimplemented bits read as zero
// - token type 1=out, 9=in, d=setup
// - eight-bit threshold, read-write, resets zero
// - token fields reset zero, read-write
// - low-speed select sets next token speed
// - host sends frame-start token every millisecond
// - device address targets handled transactions
`timescale 1ns/10ps
`include "utfr_consts.svh"
module utfr_regs #(
  parameter int FRAME_CYCLES = `UTFR_FRAME_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      hostMode,
  input  wire logic                      rxFrameStart,
  input  wire logic [10:0]               rxFrameNumber,
  input  wire logic                      tokenDone,
  input  wire logic [6:0]                targetAddress,
  output logic                           tokenStart,
  output utfr_pkg::utfr_token_kind_type  tokenKind,
  output logic [3:0]                     tokenEndpoint,
  output logic [6:0]                     tokenAddress,
  output logic                           tokenLowSpeed,
  output logic                           tokenInProgress,
  output logic                           frameStartSend,
  output logic [7:0]                     thresholdCount
);
  import utfr_pkg::*;

  typedef struct packed {
    logic        awHeld;
    logic [7:0]  awAddr;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic [10:0] frameNum;
    logic [3:0]  tokType;
    logic [3:0]  tokEndpoint;
    logic [7:0]  threshold;
    logic        lowSpeedSel;
    logic        sofEnable;
    logic        busy;
    logic        start;
    utfr_token_kind_type kind;
    logic        startLowSpeed;
    logic [6:0]  startAddr;
  } utfr_regs_state_type;

  utfr_regs_state_type state_q;
  utfr_regs_state_type state_d;
  logic        frameStartSync;
  logic        doneSync;
  logic        hostSync;
  logic        sofTick;
  logic [10:0] frameNumSync;

  function automatic utfr_token_kind_type decodeKind(input logic [3:0] pid);
    case (pid)
      `UTFR_PID_OUT:   decodeKind = UTFR_TOK_OUT;
      `UTFR_PID_IN:    decodeKind = UTFR_TOK_IN;
      `UTFR_PID_SETUP: decodeKind = UTFR_TOK_SETUP;
      default:         decodeKind = UTFR_TOK_NONE;
    endcase
  endfunction : decodeKind

  function automatic logic [7:0] mergeByte(input logic [7:0] old,
                                           input logic [7:0] val,
                                           input logic       en);
    mergeByte = en ? val : old;
  endfunction : mergeByte

  // link-side events arrive from the transceiver domain
  utfr_sync #(.WIDTH(3)) linkSync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn ({rxFrameStart, tokenDone, hostMode}),
    .syncOut ({frameStartSync, doneSync, hostSync})
  );

  // number crosses with the start flag; it is held steady around the edge
  utfr_sync #(.WIDTH(11)) numSync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn (rxFrameNumber),
    .syncOut (frameNumSync)
  );

  utfr_frame_tick #(.FRAME_CYCLES(FRAME_CYCLES)) frameTick (
    .clk    (clk),
    .rst    (rst),
    .enable (hostSync & state_q.sofEnable),
    .tick   (sofTick)
  );

  logic frameStartPrev_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frameStartPrev_q <= 1'b0;
    end else begin
      frameStartPrev_q <= frameStartSync;
    end
  end

  always_comb begin
    logic doWrite;
    logic [7:0] ctlByte;
    doWrite = 1'b0;
    ctlByte = 8'h00;
    state_d = state_q;
    state_d.start = 1'b0;
    // address and data may come in either order
    if (s_axi_awvalid && !state_q.awHeld) begin
      state_d.awHeld = 1'b1;
      state_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_q.wHeld) begin
      state_d.wHeld = 1'b1;
      state_d.wData = s_axi_wdata;
      state_d.wStrb = s_axi_wstrb;
    end
    if (state_q.bValid && s_axi_bready) begin
      state_d.bValid = 1'b0;
    end
    if (state_q.awHeld && state_q.wHeld && !state_q.bValid) begin
      doWrite = 1'b1;
      state_d.awHeld = 1'b0;
      state_d.wHeld  = 1'b0;
      state_d.bValid = 1'b1;
      state_d.bResp  = 2'b00;
    end
    // hardware capture and completion, ahead of software writes
    if (frameStartSync && !frameStartPrev_q) begin
      state_d.frameNum = frameNumSync;
    end
    if (doneSync) begin
      state_d.busy = 1'b0;
    end
    if (doWrite) begin
      case (state_q.awAddr[7:2])
        6'(`UTFR_OFF_TOKEN >> 2): begin
          if (state_q.wStrb[0]) begin
            state_d.tokType     = state_q.wData[7:4];
            state_d.tokEndpoint = state_q.wData[3:0];
            state_d.busy        = 1'b1;
            state_d.start       = 1'b1;
            state_d.kind        = decodeKind(state_q.wData[7:4]);
            state_d.startLowSpeed = state_q.lowSpeedSel;
            state_d.startAddr   = targetAddress;
          end
        end
        6'(`UTFR_OFF_THRESHOLD >> 2): begin
          state_d.threshold = mergeByte(state_q.threshold,
                                        state_q.wData[7:0],
                                        state_q.wStrb[0]);
        end
        6'(`UTFR_OFF_CONTROL >> 2): begin
          ctlByte = {state_q.sofEnable, state_q.lowSpeedSel, 6'h00};
          if (state_q.wStrb[0]) begin
            state_d.lowSpeedSel = state_q.wData[`UTFR_CTL_LOWSPEED];
          end
          if (state_q.wStrb[1]) begin
            state_d.sofEnable = state_q.wData[`UTFR_CTL_FRAME_START_GENERATION_ENABLE];
          end
        end
        // read-only and unmapped offsets ignore writes
        default: state_d.bResp = 2'b00;
      endcase
    end
    if (state_q.rValid && s_axi_rready) begin
      state_d.rValid = 1'b0;
    end
    if (s_axi_arvalid && !state_q.rValid) begin
      state_d.rValid = 1'b1;
      state_d.rResp  = 2'b00;
      state_d.rData  = 32'h0;
      case (s_axi_araddr[7:2])
        6'(`UTFR_OFF_FRAME_LOW >> 2):
          state_d.rData[7:0] = state_q.frameNum[7:0];
        6'(`UTFR_OFF_FRAME_HIGH >> 2):
          state_d.rData[2:0] = state_q.frameNum[10:8];
        6'(`UTFR_OFF_TOKEN >> 2):
          state_d.rData[7:0] = {state_q.tokType, state_q.tokEndpoint};
        6'(`UTFR_OFF_THRESHOLD >> 2):
          state_d.rData[7:0] = state_q.threshold;
        6'(`UTFR_OFF_CONTROL >> 2): begin
          state_d.rData[`UTFR_CTL_LOWSPEED] = state_q.lowSpeedSel;
          state_d.rData[`UTFR_CTL_FRAME_START_GENERATION_ENABLE]    = state_q.sofEnable;
        end
        6'(`UTFR_OFF_STATUS >> 2): begin
          state_d.rData[`UTFR_STS_BUSY]     = state_q.busy;
          state_d.rData[`UTFR_STS_LOWSPEED] = state_q.startLowSpeed;
        end
        default: state_d.rResp = 2'b10;
      endcase
    end
    if (ctlByte == 8'hff) begin
      state_d.bResp = 2'b00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign s_axi_awready   = !state_q.awHeld;
  assign s_axi_wready    = !state_q.wHeld;
  assign s_axi_bvalid    = state_q.bValid;
  assign s_axi_bresp     = state_q.bResp;
  assign s_axi_arready   = !state_q.rValid;
  assign s_axi_rvalid    = state_q.rValid;
  assign s_axi_rdata     = state_q.rData;
  assign s_axi_rresp     = state_q.rResp;
  assign tokenStart      = state_q.start;
  assign tokenKind       = state_q.kind;
  assign tokenEndpoint   = state_q.tokEndpoint;
  assign tokenAddress    = state_q.startAddr;
  assign tokenLowSpeed   = state_q.startLowSpeed;
  assign tokenInProgress = state_q.busy;
  assign frameStartSend  = sofTick;
  assign thresholdCount  = state_q.threshold;
endmodule : utfr_regs

/* utfr_regs_props.sv */
// port assertions for the token and frame register block
`timescale 1ns/10ps
module utfr_regs_props #(
  parameter int FRAME_CYCLES = 50
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        tokenStart,
  input wire logic        tokenDone,
  input wire logic        tokenInProgress,
  input wire logic        frameStartSend
);
  logic [31:0] gap_q;
  // cycles since the last frame-start pulse
  always_ff @(posedge clk or posedge rst) begin
    gap_q <= (rst | frameStartSend) ? 32'h0 : gap_q + 32'h1;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  a_start_pulse: assert property (tokenStart |=> !tokenStart)
    else $error("token start longer than one cycle");
  a_start_busy: assert property (tokenStart |-> ##[0:1] tokenInProgress)
    else $error("token start without busy");
  // done is synchronised, so busy is already clear at the fourth sample; five leaves a margin
  a_busy_clear: assert property (tokenDone [*5] |-> !tokenInProgress)
    else $error("busy still set after done");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped while stalled");
  a_wresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped while stalled");
  a_sof_pulse: assert property (frameStartSend |=> !frameStartSend)
    else $error("frame start longer than one cycle");
  a_sof_gap: assert property (frameStartSend |-> gap_q >= FRAME_CYCLES - 1)
    else $error("frame starts too close");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |->
    s_axi_rdata == 32'h0)
    else $error("error read carries data");
endmodule : utfr_regs_props

/* utfr_sync.sv */
// two-stage synchroniser for pin-level inputs
`timescale 1ns/10ps
module utfr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } utfr_sync_state_type;
  utfr_sync_state_type state_q;
  utfr_sync_state_type state_d;

  always_comb begin
    state_d        = state_q;
    state_d.stage1 = asyncIn;
    state_d.stage2 = state_q.stage1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign syncOut = state_q.stage2;
endmodule : utfr_sync
